// ### src/io_decode_pkg.sv
/*
  io_decode_pkg: constants, types and helper functions shared by the
  I/O space decode and cycle control block.
  Assumes a single system clock and a bus master that holds its request
  fields stable while the I/O request is low.
*/
package io_decode_pkg;

  // bank code that selects the internal register bank
  localparam logic [2:0] BANK_INTERNAL = 3'h0;

  // cycle type encoding
  localparam logic [1:0] CT_SLOW = 2'h0;
  localparam logic [1:0] CT_MEDIUM = 2'h1;
  localparam logic [1:0] CT_FAST = 2'h2;
  localparam logic [1:0] CT_SYNC = 2'h3;

  // extra system clock cycles added to a peripheral cycle, per type
  localparam logic [2:0] EXTRA_SLOW = 3'h4;
  localparam logic [2:0] EXTRA_MEDIUM = 3'h3;
  localparam logic [2:0] EXTRA_FAST = 3'h2;
  localparam logic [2:0] EXTRA_SYNC = 3'h1;

  // an internal register access takes this many clock cycles, no wait states
  localparam int INTERNAL_ACCESS_CYCLES = 2;

  // reset values: active-low selects all negated, register index and wait count zero
  localparam logic [6:0] SELECT_IDLE = 7'h7F;
  localparam logic [4:0] REG_INDEX_RESET = 5'h00;
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // request group presented by the bus master
  typedef struct packed {
    logic cs;                          // chip select, high selects this device
    logic [2:0] bank_code;             // bank select
    logic [1:0] cycle_type;            // peripheral timing type
    logic [4:0] register_select_lines; // word index of internal register
    logic write;                       // high for write, low for read
  } io_req_t;

  // internal register bank access towards the register file
  typedef struct packed {
    logic strobe;     // high for the whole internal access
    logic write;      // direction of that access
    logic [4:0] index; // word index of the register
  } reg_access_t;

  // one-hot controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_GRANT = 4'b0100,
    ST_INT = 4'b1000
  } ctl_state_t;

  // number of extra cycles for a given cycle type
  function automatic logic [2:0] extra_cycles(input logic [1:0] ctype);
    logic [2:0] n;
    n = EXTRA_SLOW;
    case (ctype)
      CT_SLOW: n = EXTRA_SLOW;
      CT_MEDIUM: n = EXTRA_MEDIUM;
      CT_FAST: n = EXTRA_FAST;
      default: n = EXTRA_SYNC;
    endcase
    return n;
  endfunction : extra_cycles

  // active-low one-hot select for banks 1..7; bank 0 selects nothing
  function automatic logic [6:0] bank_select_n(input logic [2:0] bank);
    logic [6:0] sel;
    sel = SELECT_IDLE;
    if (bank != BANK_INTERNAL) begin
      sel[bank - 3'h1] = 1'b0;
    end
    return sel;
  endfunction : bank_select_n

endpackage : io_decode_pkg

// ### src/wait_counter.sv
/*
  wait_counter: down-counter that holds the remaining extra cycles of a
  peripheral access.
  Assumes load and run are never both high in one cycle's intent; load wins.
*/
`timescale 1ns/1ps

module wait_counter (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [2:0] load_value,
  input wire logic run,
  output logic expired
);
  import io_decode_pkg::*;

  logic [2:0] count_q;

  // load on the take edge, then count down to zero and stay there
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_q <= COUNT_RESET;
    end else if (load) begin
      count_q <= load_value;
    end else if (run && count_q != COUNT_RESET) begin
      count_q <= count_q - 3'h1;
    end
  end

  assign expired = (count_q == COUNT_RESET);

endmodule : wait_counter

// ### src/io_space_decode.sv
/*
  io_space_decode: bank decode, cycle timing and bus latch control for the
  I/O controller on the request/grant bus.
  Assumes all inputs are synchronous to mclk and that the master keeps the
  request group stable while io_cycle_request_n is low.
*/
// Operation
// - bank code zero selects the internal register bank, others external.
// - each nonzero bank drives exactly one distinct active-low peripheral select.
// - cycle type picks one of four timings for peripheral data transfers.
// - peripheral cycles stretch by whole extra clocks depending on type.
// - internal register accesses have no wait states, two clock cycles.
// - internal access only with bank zero and chip select high.
// - internal register chosen by five select lines, one per word.
// - cycle type ignored for internal register accesses.
// - device alone drives latch control and both buffer enables.
// - active-low write strobe times external peripheral writes by type.
// - grant low ends cycle; completion when grant and request low together.
// - cycle type codes: 0 slow, 1 medium, 2 fast, 3 synchronous.
// - latch control high for internal or unselected, low for peripheral data.
// - buffer enables follow reads and writes of any bus device, even unselected.
`timescale 1ns/1ps

module io_space_decode (
  input wire logic mclk,
  input wire logic rst_b,
  input io_decode_pkg::io_req_t bus_req,
  input wire logic io_cycle_request_n,
  output logic [6:0] peripheral_select_n,
  output logic periph_read_strobe_n,
  output logic periph_write_strobe_n,
  output logic data_latch_ctrl_n,
  output logic data_latch_ctrl_oe,
  output logic read_buffer_en_n,
  output logic write_buffer_en_n,
  output logic io_cycle_grant_n,
  output logic io_cycle_grant_oe,
  output io_decode_pkg::reg_access_t reg_access
);
  import io_decode_pkg::*;

  ctl_state_t state_q;
  ctl_state_t state_d;
  logic [6:0] select_q;
  logic read_strobe_n_q;
  logic write_strobe_n_q;
  logic latch_oe_q;
  logic rbe_q;
  logic wbe_q;
  logic grant_oe_q;
  reg_access_t reg_q;
  logic request;
  logic selected;
  logic take_internal;
  logic take_periph;
  logic completion;
  logic hold_internal;
  logic wait_expired;
  logic [2:0] wait_load_value;

  // request qualifiers; chip select low leaves the request to other devices
  // on the bus, so only the buffer enables and the grant-gated completion look at a bare request
  assign request = !io_cycle_request_n;
  assign selected = request && bus_req.cs;
  assign take_internal = selected && (bus_req.bank_code == BANK_INTERNAL);
  assign take_periph = selected && (bus_req.bank_code != BANK_INTERNAL);
  // completion is the edge on which our grant and the request are both low
  assign completion = grant_oe_q && request;
  // type decides the stretch; internal accesses never consult it
  assign wait_load_value = extra_cycles(bus_req.cycle_type);
  // an internal access stays open for its second cycle, which is when grant is driven low
  assign hold_internal = (state_q == ST_INT) && (state_d == ST_INT);

  // stretch counter: loaded on the take edge, counts only while waiting,
  // so an abandoned cycle leaves a stale count that the next take overwrites
  wait_counter u_wait_counter (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(state_q == ST_IDLE && take_periph),
    .load_value(wait_load_value),
    .run(state_q == ST_WAIT),
    .expired(wait_expired)
  );

  // next state; a request dropped mid-cycle abandons the cycle cleanly.
  // the master may raise its request at any edge, so every busy state
  // checks for it before anything else
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_internal) begin
          state_d = ST_INT;
        end else if (take_periph) begin
          state_d = ST_WAIT;
        end
      end
      ST_INT: begin
        if (!selected || completion) begin
          state_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (!selected) begin
          state_d = ST_IDLE;
        end else if (wait_expired) begin
          state_d = ST_GRANT;
        end
      end
      ST_GRANT: begin
        if (!selected || completion) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // controller state register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // grant: driven low one cycle before the completion edge, so an internal
  // access completes on the second edge after its take edge and a peripheral
  // one that many edges plus its stretch; never raised once the request is gone
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      grant_oe_q <= 1'b0;
    end else begin
      grant_oe_q <= (hold_internal || state_d == ST_GRANT) && !completion;
    end
  end

  // peripheral select held from the take edge until completion or abort;
  // it is cleared on the same edge as grant so no select outlives its cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      select_q <= SELECT_IDLE;
    end else if (state_q == ST_IDLE && take_periph) begin
      select_q <= bank_select_n(bus_req.bank_code);
    end else if (state_d == ST_IDLE) begin
      select_q <= SELECT_IDLE;
    end
  end

  // read and write strobes span the whole stretched peripheral cycle; they are
  // kept active low in the flip-flops so the pins need no gate after them
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      read_strobe_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
    end else if (state_q == ST_IDLE && take_periph) begin
      read_strobe_n_q <= bus_req.write;
      write_strobe_n_q <= !bus_req.write;
    end else if (state_d == ST_IDLE) begin
      read_strobe_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
    end
  end

  // latch control: pulled low only while a peripheral cycle is open, so the
  // latches stay transparent for internal accesses and when not selected
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      latch_oe_q <= 1'b0;
    end else begin
      latch_oe_q <= (state_d == ST_WAIT || state_d == ST_GRANT);
    end
  end

  // buffer enables follow any request on the bus, chip select or not;
  // they lag the request by one edge since every output is registered,
  // a limitation the bus master must allow for before data is driven
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rbe_q <= 1'b1;
      wbe_q <= 1'b1;
    end else begin
      rbe_q <= !(request && !bus_req.write);
      wbe_q <= !(request && bus_req.write);
    end
  end

  // internal register access: index from the word select lines; only the
  // strobe is dropped at the end, the other fields keep the last access
  // so a register file may read them without extra hold logic
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_q.strobe <= 1'b0;
      reg_q.write <= 1'b0;
      reg_q.index <= REG_INDEX_RESET;
    end else if (state_q == ST_IDLE && take_internal) begin
      reg_q.strobe <= 1'b1;
      reg_q.write <= bus_req.write;
      reg_q.index <= bus_req.register_select_lines;
    end else if (state_d == ST_IDLE) begin
      reg_q.strobe <= 1'b0;
    end
  end

  // outputs, each straight from a flip-flop; the two open-drain pins carry
  // a constant low value and are steered by their registered enables
  assign peripheral_select_n = select_q;
  assign periph_read_strobe_n = read_strobe_n_q;
  assign periph_write_strobe_n = write_strobe_n_q;
  assign data_latch_ctrl_n = 1'b0; // open drain: only ever pulls low
  assign data_latch_ctrl_oe = latch_oe_q;
  assign read_buffer_en_n = rbe_q;
  assign write_buffer_en_n = wbe_q;
  assign io_cycle_grant_n = 1'b0; // open drain: only ever pulls low
  assign io_cycle_grant_oe = grant_oe_q;
  assign reg_access = reg_q;

endmodule : io_space_decode

// ### tb/io_space_decode_monitor.sv
/*
  io_space_decode_monitor: port assertions for io_space_decode.
  Assumes it is bound to the design and that the master holds its request fields.
*/
`timescale 1ns/1ps
module io_space_decode_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input io_decode_pkg::io_req_t bus_req,
  input wire logic io_cycle_request_n,
  input wire logic [6:0] peripheral_select_n,
  input wire logic periph_write_strobe_n,
  input wire logic data_latch_ctrl_oe,
  input wire logic read_buffer_en_n,
  input wire logic write_buffer_en_n,
  input wire logic io_cycle_grant_oe,
  input io_decode_pkg::reg_access_t reg_access
);
  import io_decode_pkg::*;
  logic busy_q;
  logic [2:0] cnt_q;
  logic done;
  logic [2:0] extra;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // completion edge and the stretch that the type on the bus asks for
  assign done = io_cycle_grant_oe && !io_cycle_request_n;
  assign extra = bus_req.cycle_type == CT_SLOW ? EXTRA_SLOW : bus_req.cycle_type == CT_MEDIUM ? EXTRA_MEDIUM :
    bus_req.cycle_type == CT_FAST ? EXTRA_FAST : EXTRA_SYNC;
  // edges since the take edge; a raised request ends the cycle, so aborts never count
  always_ff @(posedge mclk) begin
    if (!rst_b || io_cycle_request_n || done) begin
      busy_q <= 1'b0;
      cnt_q <= COUNT_RESET;
    end else if (!busy_q && bus_req.cs) begin
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  a_int_two_cycles: assert property (busy_q && done && bus_req.bank_code == BANK_INTERNAL |-> cnt_q == 3'h1)
    else $error("internal access length wrong");
  a_per_stretch: assert property (busy_q && done && bus_req.bank_code != BANK_INTERNAL |-> cnt_q == extra + 3'h1)
    else $error("peripheral stretch wrong");
  a_grant_cause: assert property (io_cycle_grant_oe |-> !$past(io_cycle_request_n) && $past(bus_req.cs))
    else $error("grant without request");
  a_sel_onehot: assert property ($onehot0(~peripheral_select_n))
    else $error("more than one select low");
  a_sel_bank: assert property (peripheral_select_n != SELECT_IDLE |-> $past(bus_req.cs) &&
    $past(bus_req.bank_code) != BANK_INTERNAL && !peripheral_select_n[$past(bus_req.bank_code) - 3'h1])
    else $error("select does not match bank");
  a_wstrobe_dir: assert property (!periph_write_strobe_n |-> $past(bus_req.write) && $past(bus_req.cs))
    else $error("write strobe outside a write");
  a_latch_periph: assert property (data_latch_ctrl_oe == (peripheral_select_n != SELECT_IDLE))
    else $error("latch control out of step");
  a_rbe_follow: assert property ($past(rst_b) |-> read_buffer_en_n == ($past(io_cycle_request_n) ||
    $past(bus_req.write))) else $error("read buffer enable wrong");
  a_wbe_follow: assert property ($past(rst_b) |-> write_buffer_en_n == ($past(io_cycle_request_n) ||
    !$past(bus_req.write))) else $error("write buffer enable wrong");
  a_grant_drop: assert property (done |=> !io_cycle_grant_oe)
    else $error("grant held past completion");
  a_reg_index: assert property (reg_access.strobe |-> reg_access.index == $past(bus_req.register_select_lines) &&
    $past(bus_req.bank_code) == BANK_INTERNAL) else $error("register access wrong");
endmodule : io_space_decode_monitor

bind io_space_decode io_space_decode_monitor io_space_decode_monitor_i (.mclk(mclk), .rst_b(rst_b),
  .bus_req(bus_req), .io_cycle_request_n(io_cycle_request_n), .peripheral_select_n(peripheral_select_n),
  .periph_write_strobe_n(periph_write_strobe_n), .data_latch_ctrl_oe(data_latch_ctrl_oe),
  .read_buffer_en_n(read_buffer_en_n), .write_buffer_en_n(write_buffer_en_n),
  .io_cycle_grant_oe(io_cycle_grant_oe), .reg_access(reg_access));

// ### tb/io_master_model.sv
/*
  io_master_model: bus master issuing one I/O request per go pulse.
  Assumes the grant wire is resolved by the bench; abort raises the request early.
*/
`timescale 1ns/1ps
module io_master_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic abort,
  input io_decode_pkg::io_req_t cmd,
  input wire logic grant_n,
  output io_decode_pkg::io_req_t bus_req,
  output logic req_n,
  output logic done,
  output logic [2:0] lat
);
  import io_decode_pkg::*;
  logic rel_q;
  logic [2:0] cnt_q;
  // fields stay put until a cycle after release, then go to inverted values
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    rel_q <= 1'b0;
    if (!rst_b) begin
      bus_req <= '0;
      req_n <= 1'b1;
      cnt_q <= 3'h0;
      lat <= 3'h0;
    end else if (rel_q) begin
      bus_req <= ~bus_req;
    end else if (go && req_n) begin
      bus_req <= cmd;
      req_n <= 1'b0;
      cnt_q <= 3'h0;
    end else if (!req_n && (!grant_n || abort)) begin
      req_n <= 1'b1;
      rel_q <= 1'b1;
      done <= !grant_n;
      lat <= cnt_q;
    end else if (!req_n) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : io_master_model

// ### tb/test_io_space_decode.sv
/*
  test_io_space_decode: table of accesses, then refusal, abort and reset cases.
  Assumes io_master_model as the far side and the bound monitor.
*/
`timescale 1ns/1ps
module test_io_space_decode;
  import io_decode_pkg::*;
  typedef struct packed {io_req_t r; logic [2:0] n; logic [6:0] s;} row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic abort = 1'b0;
  io_req_t cmd = '0;
  io_req_t bus_req;
  logic req_n, done, rs_n, ws_n, bl_n, bl_oe, rbe_n, wbe_n, gnt_n, gnt_oe;
  logic [2:0] lat, st_s;
  logic [6:0] sel_n, sel_s;
  reg_access_t ra, ra_s;
  int fail_count = 0;
  int compares = 0;
  row_t rows [9];
  wire bl_w = bl_oe ? bl_n : 1'b1;
  wire gnt_w = gnt_oe ? gnt_n : 1'b1;
  always #2 mclk = ~mclk;
  // design and master; open-drain wires resolved above with pull-ups
  io_space_decode io_space_decode_i (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .io_cycle_request_n(req_n),
    .peripheral_select_n(sel_n), .periph_read_strobe_n(rs_n), .periph_write_strobe_n(ws_n),
    .data_latch_ctrl_n(bl_n), .data_latch_ctrl_oe(bl_oe), .read_buffer_en_n(rbe_n), .write_buffer_en_n(wbe_n),
    .io_cycle_grant_n(gnt_n), .io_cycle_grant_oe(gnt_oe), .reg_access(ra));
  io_master_model io_master_model_i (.mclk(mclk), .rst_b(rst_b), .go(go), .abort(abort), .cmd(cmd),
    .grant_n(gnt_w), .bus_req(bus_req), .req_n(req_n), .done(done), .lat(lat));
  // outputs as they stand at each completion edge
  always @(posedge mclk) begin
    if (!gnt_w && !req_n) begin
      sel_s <= sel_n;
      ra_s <= ra.strobe ? ra : '0;
      st_s <= {rs_n, ws_n, bl_w};
    end
  end
  task chk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task issue(input io_req_t r);
    @(posedge mclk);
    go <= 1'b1;
    cmd <= r;
    @(posedge mclk);
    go <= 1'b0;
  endtask : issue
  task run(input io_req_t r);
    issue(r);
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge mclk);
  endtask : run
  task wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // watchdog far beyond the hundred-odd cycles the tests need
  initial begin
    #40000;
    fail_count++;
    wrap_up();
  end
  // table: request, edges to completion, select low at completion
  initial begin
    rows[0] = {1'b1, 3'h0, CT_SYNC, 5'h05, 1'b0, 3'h2, 7'h7F};
    rows[1] = {1'b1, 3'h0, CT_SLOW, 5'h1F, 1'b1, 3'h2, 7'h7F};
    rows[2] = {1'b1, 3'h1, CT_SLOW, 5'h02, 1'b0, 3'h6, 7'h7E};
    rows[3] = {1'b1, 3'h2, CT_MEDIUM, 5'h03, 1'b1, 3'h5, 7'h7D};
    rows[4] = {1'b1, 3'h3, CT_FAST, 5'h04, 1'b0, 3'h4, 7'h7B};
    rows[5] = {1'b1, 3'h4, CT_SYNC, 5'h05, 1'b1, 3'h3, 7'h77};
    rows[6] = {1'b1, 3'h5, CT_SLOW, 5'h06, 1'b1, 3'h6, 7'h6F};
    rows[7] = {1'b1, 3'h6, CT_MEDIUM, 5'h07, 1'b0, 3'h5, 7'h5F};
    rows[8] = {1'b1, 3'h7, CT_FAST, 5'h08, 1'b1, 3'h4, 7'h3F};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      run(rows[k].r);
      chk({6'h00, done}, 7'h01);
      chk({4'h0, lat}, {4'h0, rows[k].n});
      chk(sel_s, rows[k].s);
      chk(ra_s, rows[k].r.bank_code == 3'h0 ? {1'b1, rows[k].r.write, rows[k].r.register_select_lines} : 7'h00);
      chk({4'h0, st_s}, rows[k].r.bank_code == 3'h0 ? 7'h07 : {4'h0, rows[k].r.write, ~rows[k].r.write, 1'b0});
    end
    // unselected read: read buffer still open, nothing else moves
    run({1'b0, 3'h2, CT_FAST, 5'h00, 1'b0});
    chk({2'h0, rbe_n, bl_oe, gnt_oe, done, bl_n}, 7'h00);
    @(posedge mclk);
    abort <= 1'b1;
    @(posedge mclk);
    abort <= 1'b0;
    // slow write cut short by the master before its grant
    issue(rows[6].r);
    repeat (3) @(posedge mclk);
    abort <= 1'b1;
    @(posedge mclk);
    abort <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(sel_n, 7'h7F);
    chk({4'h0, ws_n, gnt_oe, gnt_n}, 7'h04);
    // reset in mid-cycle returns every output to idle, then a fresh access works
    issue(rows[2].r);
    repeat (2) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(sel_n, SELECT_IDLE);
    chk({2'h0, rs_n, bl_oe, gnt_oe, rbe_n, wbe_n}, 7'h13);
    @(posedge mclk);
    rst_b <= 1'b1;
    run(rows[1].r);
    chk({4'h0, lat}, 7'h02);
    wrap_up();
  end
endmodule : test_io_space_decode
